//--- switchover_pkg.sv
// Shared constants and types for the backup switchover controller
package switchover_pkg;

    localparam int NPRIME = 9;
    localparam int PW = 4;
    localparam int DW = 12;
    localparam int TBW = 24;
    localparam int BU1 = 0;
    localparam int BU2 = 1;
    localparam int PATH_MOD = 0;
    localparam int PATH_DEMOD = 1;
    // Index of the ninth prime, which is backup two run as traffic
    localparam int TRAFFIC_PRIME = 8;

    // Delays are counted in tenths of a second; 299.9 s
    localparam logic [DW-1:0] FAULT_DELAY_MAX = 12'hbb7;
    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_NS = 100000000;
    localparam int TICK_CYCLES_DEF = TICK_NS / CLK_PERIOD_NS;

    localparam logic [1:0] MAX_ATTEMPTS = 2'h3;
    localparam logic [1:0] LAST_ATTEMPT = MAX_ATTEMPTS - 2'h1;
    localparam logic [PW-1:0] PRIME_NONE = 4'h0;
    localparam logic [PW-1:0] MANUAL_MAX = 4'h8;
    localparam logic [PW-1:0] MANUAL_MAX_1TO9 = 4'h9;
    localparam logic [PW-1:0] PRIO_NONE = 4'hf;
    localparam logic [1:0] PATHS_NONE = 2'h0;
    localparam logic [1:0] PATHS_BOTH = 2'h3;

    typedef enum logic [1:0] {
        MODE_MANUAL = 2'h0,
        MODE_AUTO_REV = 2'h1,
        MODE_AUTO_NONREV = 2'h3
    } buMode_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ACQ = 2'h1,
        ST_SERVE = 2'h3
    } buState_t;

endpackage

//--- timebase_if.sv
// Tenth-second tick and clock enable shared by the delay counters
`timescale 1ns/1ps
`default_nettype none
interface timebase_if;
    logic tick;
    logic ce;
    modport src (output tick, output ce);
    modport sink (input tick, input ce);
endinterface
`default_nettype wire

//--- fault_delay_timer.sv
// Per-path fault delay counter
`timescale 1ns/1ps
`default_nettype none
module fault_delay_timer
    import switchover_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    timebase_if.sink tb,
    input wire logic fault,
    input wire logic [DW-1:0] delay,
    output logic expired
);

typedef struct packed {
    logic [DW-1:0] count;
    logic expired;
} tmr_t;

tmr_t s;
tmr_t next_s;
logic [DW-1:0] limit;

always_comb begin
    limit = (delay > FAULT_DELAY_MAX) ? FAULT_DELAY_MAX : delay;
    next_s = s;
    if (!fault) begin
        next_s = '0;
    // delay per path, 0 to 299.9 s
    end else if (s.count >= limit) begin
        next_s.expired = 1'b1;
    end else if (tb.tick) begin
        next_s.count = s.count + 1'b1;
    end
end

always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        s <= '0;
    end else if (tb.ce) begin
        s <= next_s;
    end
end

assign expired = s.expired;

endmodule
`default_nettype wire

//--- acq_watch.sv
// Acquisition delay supervisor for one backup demodulator
`timescale 1ns/1ps
`default_nettype none
module acq_watch
    import switchover_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    timebase_if.sink tb,
    input wire logic run,
    input wire logic [DW-1:0] delay,
    output logic timeout
);

typedef struct packed {
    logic [DW-1:0] count;
    logic timeout;
} acq_t;

acq_t s;
acq_t next_s;

always_comb begin
    next_s = s;
    if (!run) begin
        next_s = '0;
    end else if (s.count >= delay) begin
        next_s.timeout = 1'b1;
    end else if (tb.tick) begin
        next_s.count = s.count + 1'b1;
    end
end

always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        s <= '0;
    end else if (tb.ce) begin
        s <= next_s;
    end
end

assign timeout = s.timeout;

endmodule
`default_nettype wire

//--- switchover_ctrl.sv
// Backup switchover controller for M:N modem redundancy
// Contract
// - Auto mode replaces a failed online unit whenever a backup is available.
// - A backup in manual mode never takes a failing unit automatically.
// - Manual selection: backup two 1-8; backup one 1-8, or 1-9 with traffic.
// - Revertive: release a recovered prime when a new failure finds no free backup.
// - Non-revertive: a replaced prime is never released to free the backup.
// - Manual backup commanded to prime zero releases its channel.
// - Each modulator and demodulator has its own fault delay, 0 to 299.9 s.
// - Good signal during the delay cancels switchover and resets the timer.
// - Backups are granted in order of delay expiry until none is free.
// - Switch only when still faulty at expiry and a backup is available.
// - Auto plus hot standby backs up its prime at once, ignoring delay.
// - No lock within acquisition delay: major alarm, event, status fault.
// - Three failed attempts flag the prime and drop it from that pool.
// - Free backups serve any outage; otherwise priority, revertive may preempt.
// - Priority per link on nine levels, 1 highest, 9 lowest.
// - Each backup has a prime pool, per-path or whole modem switching.
// - Backup two as traffic becomes a ninth prime covered by backup one.
// - Writing assignment, priority or mode clears the prime's attempt count.
// - Dropped prime returns to the pool on summary fault change or user action.
`timescale 1ns/1ps
`default_nettype none
module switchover_ctrl
    import switchover_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic [NPRIME-1:0] modFault,
    input wire logic [NPRIME-1:0] demodFault,
    input wire logic [1:0] backupLock,
    input wire buMode_t [1:0] buMode,
    input wire logic [1:0] hotStandby,
    input wire logic [1:0][PW-1:0] hotPrime,
    input wire logic bu2Traffic,
    input wire logic [1:0][PW-1:0] manualPrime,
    input wire logic [1:0][NPRIME-1:0] poolMod,
    input wire logic [1:0][NPRIME-1:0] poolDemod,
    input wire logic [1:0][NPRIME-1:0] wholeModemSwitching,
    input wire logic [NPRIME-1:0][PW-1:0] linkPriority,
    input wire logic [NPRIME-1:0][DW-1:0] modDelay,
    input wire logic [NPRIME-1:0][DW-1:0] demodDelay,
    input wire logic [1:0][DW-1:0] acqDelay,
    input wire logic [NPRIME-1:0] cfgWrite,
    input wire logic [NPRIME-1:0] userRestore,
    input wire logic alarmClear,
    output logic [1:0][PW-1:0] backupPrime,
    output logic [1:0][1:0] backupPaths,
    output logic [1:0] backupLocked,
    output logic [1:0][NPRIME-1:0] poolFailed,
    output logic [NPRIME-1:0] bothPathsBackupFailedFlag,
    output logic [NPRIME-1:0][1:0] attemptCount,
    output logic [1:0] statusFault,
    output logic majorAlarm,
    output logic eventPulse
);

typedef struct packed {
    buState_t [1:0] st;
    logic [1:0][PW-1:0] prime;
    logic [1:0][1:0] paths;
    logic [NPRIME-1:0][1:0] attempts;
    logic [1:0][NPRIME-1:0] failed;
    logic [NPRIME-1:0] bothFailed;
    logic [NPRIME-1:0] lastSummary;
    logic [1:0] statusFault;
    logic [1:0] locked;
    logic majorAlarm;
    logic eventPulse;
    logic tick;
    logic [TBW-1:0] tbCount;
} ctrl_t;

ctrl_t s;
ctrl_t n;

logic [NPRIME-1:0] modExp;
logic [NPRIME-1:0] demodExp;
logic [NPRIME-1:0] served;
logic [NPRIME-1:0] summary;
logic [1:0] isAuto;
logic [1:0] bestValid;
logic [1:0][PW-1:0] bestNum;
logic [1:0][PW-1:0] bestPrio;
logic [1:0][1:0] bestPaths;
logic [1:0][PW-1:0] servedPrio;
logic [1:0] recovered;
logic [1:0] acqRun;
logic [1:0] acqTimeout;
logic anyFree;
logic hot;
logic [1:0] pf;
logic grantDone;
logic otherHolds;
logic [PW-1:0] limitSel;

timebase_if tb ();
assign tb.tick = s.tick;
assign tb.ce = ce;

assign summary = modFault | demodFault;

////////////////////////////////////////////////////////////////////////////////

genvar gp;
generate
    for (gp = 0; gp < NPRIME; gp++) begin : g_unit
        fault_delay_timer u_mod (
            .clk(clk),
            .arst_n(arst_n),
            .tb(tb),
            .fault(modFault[gp]),
            .delay(modDelay[gp]),
            .expired(modExp[gp])
        );
        fault_delay_timer u_demod (
            .clk(clk),
            .arst_n(arst_n),
            .tb(tb),
            .fault(demodFault[gp]),
            .delay(demodDelay[gp]),
            .expired(demodExp[gp])
        );
    end
    for (gp = 0; gp < 2; gp++) begin : g_bu
        assign acqRun[gp] = (s.st[gp] == ST_ACQ);
        acq_watch u_acq (
            .clk(clk),
            .arst_n(arst_n),
            .tb(tb),
            .run(acqRun[gp]),
            .delay(acqDelay[gp]),
            .timeout(acqTimeout[gp])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////

// Candidate selection per backup
always_comb begin
    served = '0;
    hot = 1'b0;
    pf = PATHS_NONE;
    isAuto = '0;
    bestValid = '0;
    bestNum = '0;
    bestPrio = {PRIO_NONE, PRIO_NONE};
    bestPaths = '0;
    servedPrio = {PRIO_NONE, PRIO_NONE};
    recovered = '0;
    anyFree = 1'b0;
    for (int b = 0; b < 2; b++) begin
        isAuto[b] = (buMode[b] == MODE_AUTO_REV) || (buMode[b] == MODE_AUTO_NONREV);
        for (int p = 0; p < NPRIME; p++) begin
            if (s.st[b] != ST_IDLE && s.prime[b] == PW'(p + 1)) begin
                served[p] = 1'b1;
            end
        end
    end
    for (int b = 0; b < 2; b++) begin
        for (int p = 0; p < NPRIME; p++) begin
            hot = hotStandby[b] && (hotPrime[b] == PW'(p + 1));
            pf[PATH_MOD] = poolMod[b][p] & (hot ? modFault[p] : modExp[p]);
            pf[PATH_DEMOD] = poolDemod[b][p] & (hot ? demodFault[p] : demodExp[p]);
            if (wholeModemSwitching[b][p] && pf != PATHS_NONE) begin
                pf = PATHS_BOTH;
            end
            if (p == TRAFFIC_PRIME && (!bu2Traffic || b == BU2)) begin
                pf = PATHS_NONE;
            end
            if (s.failed[b][p] || served[p]) begin
                pf = PATHS_NONE;
            end
            // lower value wins, ties to lower prime
            if (pf != PATHS_NONE && linkPriority[p] < bestPrio[b]) begin
                bestValid[b] = 1'b1;
                bestNum[b] = PW'(p + 1);
                bestPrio[b] = linkPriority[p];
                bestPaths[b] = pf;
            end
            if (s.prime[b] == PW'(p + 1)) begin
                servedPrio[b] = linkPriority[p];
                recovered[b] = !((s.paths[b][PATH_MOD] & modFault[p])
                    | (s.paths[b][PATH_DEMOD] & demodFault[p]));
            end
        end
        // free means auto, idle and eligible
        if (isAuto[b] && s.st[b] == ST_IDLE && bestValid[b] && !(b == BU2 && bu2Traffic)) begin
            anyFree = 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////

always_comb begin
    n = s;
    grantDone = 1'b0;
    otherHolds = 1'b0;
    limitSel = MANUAL_MAX;
    n.eventPulse = 1'b0;
    if (s.tbCount >= TBW'(TICK_CYCLES - 1)) begin
        n.tbCount = '0;
        n.tick = 1'b1;
    end else begin
        n.tbCount = s.tbCount + 1'b1;
        n.tick = 1'b0;
    end
    n.lastSummary = summary;
    // Clear first so a same-cycle failure still sets it
    if (alarmClear) begin
        n.statusFault = '0;
    end
    for (int p = 0; p < NPRIME; p++) begin
        // summary change or user restores pool
        if (summary[p] != s.lastSummary[p] || userRestore[p]) begin
            n.failed[BU1][p] = 1'b0;
            n.failed[BU2][p] = 1'b0;
            n.bothFailed[p] = 1'b0;
            n.attempts[p] = 2'h0;
        end
        if (cfgWrite[p]) begin
            n.attempts[p] = 2'h0;
        end
    end
    for (int b = 0; b < 2; b++) begin
        if (b == BU2 && bu2Traffic) begin
            n.st[b] = ST_IDLE;
            n.prime[b] = PRIME_NONE;
            n.paths[b] = PATHS_NONE;
        // manual backup follows the operator only
        end else if (!isAuto[b]) begin
            limitSel = (b == BU1 && bu2Traffic) ? MANUAL_MAX_1TO9 : MANUAL_MAX;
            otherHolds = (s.st[1-b] != ST_IDLE) && (s.prime[1-b] == manualPrime[b]);
            if (manualPrime[b] == PRIME_NONE) begin
                n.st[b] = ST_IDLE;
                n.prime[b] = PRIME_NONE;
                n.paths[b] = PATHS_NONE;
            end else if (manualPrime[b] <= limitSel && !otherHolds) begin
                n.st[b] = ST_SERVE;
                n.prime[b] = manualPrime[b];
                n.paths[b] = PATHS_BOTH;
            end
        end else begin
            unique case (s.st[b])
                ST_IDLE: begin
                    if (!grantDone && bestValid[b]) begin
                        n.st[b] = ST_ACQ;
                        n.prime[b] = bestNum[b];
                        n.paths[b] = bestPaths[b];
                        grantDone = 1'b1;
                    end
                end
                ST_ACQ: begin
                    if (!s.paths[b][PATH_DEMOD] || backupLock[b]) begin
                        n.st[b] = ST_SERVE;
                    end else if (acqTimeout[b]) begin
                        n.st[b] = ST_IDLE;
                        n.prime[b] = PRIME_NONE;
                        n.paths[b] = PATHS_NONE;
                        n.statusFault[b] = 1'b1;
                        n.eventPulse = 1'b1;
                        for (int p = 0; p < NPRIME; p++) begin
                            if (s.prime[b] == PW'(p + 1)) begin
                                // Saturate so a second backup cannot wrap it
                                if (s.attempts[p] != MAX_ATTEMPTS) begin
                                    n.attempts[p] = s.attempts[p] + 2'h1;
                                end
                                if (s.attempts[p] >= LAST_ATTEMPT) begin
                                    n.failed[b][p] = 1'b1;
                                    n.bothFailed[p] = (s.paths[b] == PATHS_BOTH);
                                end
                            end
                        end
                    end
                end
                ST_SERVE: begin
                    if (buMode[b] == MODE_AUTO_REV && !anyFree && bestValid[b]
                        && (recovered[b] || bestPrio[b] < servedPrio[b])) begin
                        n.st[b] = ST_IDLE;
                        n.prime[b] = PRIME_NONE;
                        n.paths[b] = PATHS_NONE;
                    end
                end
                default: begin
                    n.st[b] = ST_IDLE;
                end
            endcase
        end
    end
    // Lock status registered so the output comes from a flop
    n.locked[BU1] = (n.st[BU1] == ST_SERVE);
    n.locked[BU2] = (n.st[BU2] == ST_SERVE);
    n.majorAlarm = |n.statusFault;
end

always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
        s <= '0;
    end else if (ce) begin
        s <= n;
    end
end

////////////////////////////////////////////////////////////////////////////////

assign backupPrime = s.prime;
assign backupPaths = s.paths;
assign backupLocked = s.locked;
assign poolFailed = s.failed;
assign bothPathsBackupFailedFlag = s.bothFailed;
assign attemptCount = s.attempts;
assign statusFault = s.statusFault;
assign majorAlarm = s.majorAlarm;
assign eventPulse = s.eventPulse;

endmodule
`default_nettype wire

//--- modem_channels.sv
// Behavioural model of the prime and backup modem channels
`timescale 1ns/1ps
`default_nettype none
module modem_channels
    import switchover_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [NPRIME-1:0] modFail,
    input wire logic [NPRIME-1:0] demodFail,
    input wire logic [1:0] noLock,
    input wire logic [1:0][1:0] backupPaths,
    output logic [NPRIME-1:0] modFault,
    output logic [NPRIME-1:0] demodFault,
    output logic [1:0] backupLock
);
    logic [1:0][2:0] lockCnt;

    assign modFault = modFail;
    assign demodFault = demodFail;
    assign backupLock[0] = lockCnt[0] >= 3'h3;
    assign backupLock[1] = lockCnt[1] >= 3'h3;

    // Demod needs a few cycles to acquire; a jammed carrier never locks
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lockCnt <= '0;
        end else begin
            for (int b = 0; b < 2; b++) begin
                if (!backupPaths[b][1] || noLock[b]) begin
                    lockCnt[b] <= 3'h0;
                end else if (lockCnt[b] != 3'h7) begin
                    lockCnt[b] <= lockCnt[b] + 3'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

//--- switchover_chk.sv
// Port-level properties of the backup switchover controller
`timescale 1ns/1ps
`default_nettype none
module switchover_chk
    import switchover_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    input wire buMode_t [1:0] buMode,
    input wire logic [1:0][PW-1:0] manualPrime,
    input wire logic bu2Traffic,
    input wire logic [NPRIME-1:0] cfgWrite,
    input wire logic [NPRIME-1:0] userRestore,
    input wire logic [1:0][PW-1:0] backupPrime,
    input wire logic [1:0][1:0] backupPaths,
    input wire logic [1:0] backupLocked,
    input wire logic [1:0][NPRIME-1:0] poolFailed,
    input wire logic [NPRIME-1:0][1:0] attemptCount,
    input wire logic [1:0] statusFault,
    input wire logic majorAlarm,
    input wire logic eventPulse
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    sequence s_release0;
        ce && buMode[0] == MODE_MANUAL && manualPrime[0] == PRIME_NONE;
    endsequence
    // Both manual with distinct picks, so neither backup can claim the other's prime
    sequence s_pick1;
        ce && buMode[1] == MODE_MANUAL && buMode[0] == MODE_MANUAL && !bu2Traffic
            && manualPrime[1] != PRIME_NONE && manualPrime[1] <= MANUAL_MAX
            && manualPrime[1] != manualPrime[0] && backupPrime[0] != manualPrime[1];
    endsequence
    sequence s_acq_fail;
        $rose(eventPulse);
    endsequence

    a_manual_release: assert property (s_release0 |=> backupPrime[0] == PRIME_NONE)
        else $error("manual release left backup one busy");
    a_manual_pick: assert property (s_pick1 |=>
        backupPrime[1] == $past(manualPrime[1]) && backupPaths[1] == PATHS_BOTH)
        else $error("manual pick not taken by backup two");
    a_bu2_range: assert property (ce && buMode[1] == MODE_MANUAL
        && manualPrime[1] > MANUAL_MAX && backupPrime[1] == PRIME_NONE
        |=> backupPrime[1] == PRIME_NONE)
        else $error("backup two took an out of range prime");
    a_manual_only: assert property (ce && buMode[0] == MODE_MANUAL
        && backupPrime[0] == PRIME_NONE
        |=> backupPrime[0] == PRIME_NONE || backupPrime[0] == $past(manualPrime[0]))
        else $error("manual backup switched automatically");
    a_alarm_sum: assert property (majorAlarm == (statusFault != 2'h0))
        else $error("major alarm differs from status faults");
    a_fail_count: assert property (s_acq_fail |->
        majorAlarm && attemptCount != $past(attemptCount))
        else $error("acquisition failure without alarm or count");
    a_pool_drop: assert property (
        (poolFailed[0] & ~$past(poolFailed[0])) != 9'h000 |-> eventPulse)
        else $error("pool drop without acquisition failure");
    a_cfg_clear: assert property (ce && cfgWrite[0] |=>
        attemptCount[0] == 2'h0 || eventPulse)
        else $error("config write kept attempt count");
    a_restore_pool: assert property (ce && userRestore[0] |=>
        poolFailed[0][0] == 1'b0 && poolFailed[1][0] == 1'b0 || eventPulse)
        else $error("user restore kept pool drop");
    a_nonrev_hold: assert property (ce && buMode[0] == MODE_AUTO_NONREV
        && backupLocked[0] |=> backupLocked[0] && $stable(backupPrime[0]))
        else $error("non-revertive backup released its prime");
endmodule

bind switchover_ctrl switchover_chk chk (.clk, .arst_n, .ce, .buMode, .manualPrime, .bu2Traffic,
    .cfgWrite,
    .userRestore, .backupPrime, .backupPaths, .backupLocked, .poolFailed, .attemptCount,
    .statusFault, .majorAlarm, .eventPulse);
`default_nettype wire

//--- modem_backup_switchover_controller_bench.sv
// Self-checking bench for the backup switchover controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("mismatch at %0t: got %0h expected %0h", $time, g, e); end end
`define WAITC(c) begin k = 0; while ((c) !== 1'b1) begin step(1); k++; \
    if (k > 3000) begin failures++; print_verdict(); end end end
module modem_backup_switchover_controller_bench
    import switchover_pkg::*;
;
    int failures = 0;
    int n_checks = 0;
    int k;
    logic clk, arst_n, ce, bu2Traffic, alarmClear, majorAlarm, eventPulse;
    logic [NPRIME-1:0] modFail, demodFail, modFault, demodFault, cfgWrite, userRestore;
    logic [NPRIME-1:0] bothPathsBackupFailedFlag;
    logic [1:0] noLock, backupLock, hotStandby, backupLocked, statusFault;
    buMode_t [1:0] buMode;
    logic [1:0][PW-1:0] hotPrime, manualPrime, backupPrime;
    logic [1:0][NPRIME-1:0] poolMod, poolDemod, wholeModemSwitching, poolFailed;
    logic [NPRIME-1:0][PW-1:0] linkPriority;
    logic [NPRIME-1:0][DW-1:0] modDelay, demodDelay;
    logic [1:0][DW-1:0] acqDelay;
    logic [1:0][1:0] backupPaths;
    logic [NPRIME-1:0][1:0] attemptCount;

    // Four-cycle tick keeps tenth-second delay steps to a few cycles
    switchover_ctrl #(.TICK_CYCLES(4)) dut (.clk, .arst_n, .ce, .modFault, .demodFault,
        .backupLock, .buMode, .hotStandby, .hotPrime, .bu2Traffic, .manualPrime, .poolMod,
        .poolDemod, .wholeModemSwitching, .linkPriority, .modDelay, .demodDelay, .acqDelay,
        .cfgWrite, .userRestore, .alarmClear, .backupPrime, .backupPaths, .backupLocked,
        .poolFailed, .bothPathsBackupFailedFlag, .attemptCount, .statusFault, .majorAlarm,
        .eventPulse);
    modem_channels partner (.clk, .arst_n, .modFail, .demodFail, .noLock, .backupPaths,
        .modFault, .demodFault, .backupLock);

    task automatic print_verdict;
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // manual picks
    task automatic tManual;
        @(posedge clk);
        modFail[0] <= 1'b1;
        manualPrime <= {4'h9, 4'h9};
        step(20);
        `CHK(backupPrime, 8'h00)
        @(posedge clk);
        bu2Traffic <= 1'b1;
        step(2);
        `CHK(backupPrime[0], 4'h9)
        @(posedge clk);
        bu2Traffic <= 1'b0;
        manualPrime <= {4'h8, 4'h0};
        step(2);
        `CHK(backupPrime, 8'h80)
        `CHK(backupPaths[1], PATHS_BOTH)
        @(posedge clk);
        manualPrime[1] <= 4'h0;
        modFail[0] <= 1'b0;
    endtask

    task automatic tDelay;
        @(posedge clk);
        buMode[0] <= MODE_AUTO_REV;
        modFail[0] <= 1'b1;
        repeat (6) @(posedge clk);
        modFail[0] <= 1'b0;
        step(30);
        `CHK(backupPrime[0], 4'h0)
        @(posedge clk);
        modFail[0] <= 1'b1;
        `WAITC(backupPrime[0] == 4'h1)
        `CHK(k inside {[9:20]}, 1'b1)
        `CHK(backupPaths[0], 2'h1)
        step(1);
        `CHK(backupLocked[0], 1'b1)
    endtask

    task automatic tRevert;
        @(posedge clk);
        linkPriority[1] <= 4'h2;
        modFail[0] <= 1'b0;
        modFail[1] <= 1'b1;
        `WAITC(backupPrime[0] == 4'h2)
        `CHK(k < 10, 1'b1)
    endtask

    task automatic tNonRev;
        @(posedge clk);
        buMode[0] <= MODE_AUTO_NONREV;
        modFail[1] <= 1'b0;
        modFail[2] <= 1'b1;
        step(40);
        `CHK(backupPrime[0], 4'h2)
        @(posedge clk);
        buMode[0] <= MODE_MANUAL;
        modFail[2] <= 1'b0;
        step(2);
        `CHK(backupPrime[0], 4'h0)
    endtask

    // failed acquisition, restored by user, then by fault change
    task automatic tAcq;
        @(posedge clk);
        noLock[0] <= 1'b1;
        demodDelay[0] <= 12'h001;
        acqDelay[0] <= 12'h002;
        buMode[0] <= MODE_AUTO_REV;
        demodFail[0] <= 1'b1;
        for (int r = 0; r < 2; r++) begin
            for (int i = 1; i <= 3; i++) begin
                `WAITC(eventPulse)
                `CHK({statusFault[0], majorAlarm}, 2'h3)
                `CHK(attemptCount[0], 2'(i))
                step(1);
            end
            `CHK(poolFailed[0][0], 1'b1)
            `CHK(bothPathsBackupFailedFlag[0], 1'b0)
            step(40);
            `CHK(backupPrime[0], 4'h0)
            if (r == 0) begin
                @(posedge clk);
                cfgWrite[0] <= 1'b1;
                @(posedge clk);
                cfgWrite[0] <= 1'b0;
                step(1);
                `CHK(attemptCount[0], 2'h0)
                @(posedge clk);
                alarmClear <= 1'b1;
                userRestore[0] <= 1'b1;
                @(posedge clk);
                alarmClear <= 1'b0;
                userRestore[0] <= 1'b0;
                step(2);
                `CHK({majorAlarm, poolFailed[0][0]}, 2'h0)
            end else begin
                @(posedge clk);
                demodFail[0] <= 1'b0;
                noLock[0] <= 1'b0;
                step(2);
                `CHK(poolFailed[0][0], 1'b0)
            end
        end
    endtask

    task automatic tHot;
        @(posedge clk);
        modDelay[4] <= 12'h064;
        wholeModemSwitching[1][4] <= 1'b1;
        hotPrime[1] <= 4'h5;
        hotStandby[1] <= 1'b1;
        buMode[1] <= MODE_AUTO_REV;
        repeat (3) @(posedge clk);
        modFail[4] <= 1'b1;
        `WAITC(backupPrime[1] == 4'h5)
        `CHK(k < 5, 1'b1)
        `CHK(backupPaths[1], PATHS_BOTH)
        `WAITC(backupLocked[1])
        `CHK(k < 10, 1'b1)
    endtask

    task automatic tTraffic;
        @(posedge clk);
        buMode[1] <= MODE_MANUAL;
        modFail[4] <= 1'b0;
        bu2Traffic <= 1'b1;
        poolMod[0][8] <= 1'b1;
        @(posedge clk);
        modFail[8] <= 1'b1;
        ce <= 1'b0;
        step(20);
        `CHK(backupPrime[0], 4'h0)
        @(posedge clk);
        ce <= 1'b1;
        `WAITC(backupPrime[0] == 4'h9)
        `CHK(backupPrime[1], 4'h0)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        arst_n = 1'b0;
        ce = 1'b1;
        bu2Traffic = 1'b0;
        alarmClear = 1'b0;
        buMode[0] = MODE_MANUAL;
        buMode[1] = MODE_MANUAL;
        {modFail, demodFail, cfgWrite, userRestore} = '0;
        {noLock, hotStandby, hotPrime, manualPrime} = '0;
        wholeModemSwitching = '0;
        poolMod = {9'h0f0, 9'h00f};
        poolDemod = {9'h0f0, 9'h00f};
        linkPriority = {NPRIME{4'h5}};
        modDelay = '0;
        modDelay[0] = 12'h003;
        demodDelay = '0;
        acqDelay = {12'h002, 12'h002};
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        step(2);
        tManual();
        tDelay();
        tRevert();
        tNonRev();
        tAcq();
        tHot();
        tTraffic();
        print_verdict();
    end
endmodule
`default_nettype wire
